// ==== core/osc_divider_freq_config_regs.sv ====
// Divider and frequency register bank behind a two-wire serial slave
//
// Function
// RL1 - Decode high speed select to divide 4..11
// RL2 - Output select holds divide ratio minus one
// RL3 - Odd output ratios above one round up
// RL4 - Output select split: reg7 4:0, reg8 7:6
// RL5 - 38-bit word from reg8 5:0 through reg12
// RL6 - Register 13 holds alternate divider selects
// RL7 - Frequency word scaled down by two^28
// RL8 - Master freezes, then unfreezes within 10 ms; the bank has no freeze bit, so each written byte takes effect at once
// RL9 - All bits byte readable and writable serially
// RL10 - Output equals oscillator over both ratios
`default_nettype none

module osc_divider_freq_config_regs
  import osc_cfg_pkg::*;
(
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_srst,
  // Serial bus pins, open drain data
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda_out,
  output logic o_sda_oe,
  // Primary settings
  output logic [3:0] o_hs_ratio,
  output logic o_hs_sel_unused,
  output logic [7:0] o_out_div_ratio,
  output logic [10:0] o_total_div_ratio,
  output logic [FREQ_W-1:0] o_osc_freq_control_word,
  output logic [FREQ_INT_W-1:0] o_osc_freq_int,
  // Alternate settings
  output logic [3:0] o_alt_hs_ratio,
  output logic o_alt_hs_sel_unused,
  output logic [4:0] o_alt_output_divider_sel_hi
);

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  // Divide ratio for a high speed select code, zero for unused codes
  function automatic logic [3:0] hs_ratio(input logic [2:0] sel);
    logic [3:0] r;
    r = 4'h0;
    case (sel)
      3'b000: r = 4'h4; // RL1
      3'b001: r = 4'h5;
      3'b010: r = 4'h6;
      3'b011: r = 4'h7;
      3'b101: r = 4'h9;
      3'b111: r = 4'hb;
      default: r = 4'h0; // Codes 100 and 110 must not be programmed
    endcase
    return r;
  endfunction : hs_ratio

  // True when the register number falls inside the bank
  function automatic logic in_map(input logic [7:0] num);
    return (num >= REG_DIVIDER_SELECT) && (num <= REG_ALT_DIVIDER_SELECT);
  endfunction : in_map

  // Storage index of a register number
  function automatic logic [IDX_W-1:0] to_idx(input logic [7:0] num);
    logic [7:0] d;
    d = num - REG_DIVIDER_SELECT;
    return d[IDX_W-1:0];
  endfunction : to_idx

  // ----------------------------------------------------------------
  // Pin synchronisers and edge detection
  // ----------------------------------------------------------------
  logic scl_s1_q, scl_s2_q, scl_prev_q; // Clock pin stages
  logic sda_s1_q, sda_s2_q, sda_prev_q; // Data pin stages

  // Two flip-flops per pin, then a history stage for edges
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      {scl_s1_q, scl_s2_q, scl_prev_q} <= 3'b111;
      {sda_s1_q, sda_s2_q, sda_prev_q} <= 3'b111;
    end else begin
      {scl_s1_q, scl_s2_q, scl_prev_q} <= {i_scl, scl_s1_q, scl_s2_q};
      {sda_s1_q, sda_s2_q, sda_prev_q} <= {i_sda, sda_s1_q, sda_s2_q};
    end
  end

  wire logic scl_rise = scl_s2_q && !scl_prev_q; // Data sampling edge
  wire logic scl_fall = !scl_s2_q && scl_prev_q; // Data change edge
  wire logic start_cond = scl_s2_q && scl_prev_q && !sda_s2_q && sda_prev_q;
  wire logic stop_cond = scl_s2_q && scl_prev_q && sda_s2_q && !sda_prev_q;

  // ----------------------------------------------------------------
  // Serial slave state
  // ----------------------------------------------------------------
  slave_state_t state_q, state_d; // Current and next state
  slave_state_t after_ack_q, after_ack_d; // State entered after acknowledge
  logic [7:0] shift_q, shift_d; // Received byte
  logic [2:0] cnt_q, cnt_d; // Bit counter inside a byte
  logic got_q, got_d; // Eight bits seen, waiting for falling edge
  logic [7:0] ptr_q, ptr_d; // Register number pointer
  logic oe_q, oe_d; // Pulls data low while set
  logic we_d; // One-cycle storage write
  logic [7:0] rd_byte; // Byte addressed by the pointer

  wire logic rx_state = (state_q == S_DEV) || (state_q == S_REG) || (state_q == S_WDATA);
  wire logic addr_match = (shift_q[7:1] == SLAVE_ADDR);
  wire logic ptr_mapped = in_map(ptr_q);
  wire logic [IDX_W-1:0] ptr_idx = to_idx(ptr_q);
  wire logic [2:0] tx_bit = ~cnt_q; // Most significant bit first

  // Next state of the byte protocol, single-byte and sequential access
  always_comb begin
    state_d = state_q;
    after_ack_d = after_ack_q;
    shift_d = shift_q;
    cnt_d = cnt_q;
    got_d = got_q;
    ptr_d = ptr_q;
    oe_d = oe_q;
    we_d = 1'b0;
    if (start_cond) begin
      // Start or repeated start restarts addressing
      state_d = S_DEV;
      cnt_d = 3'd0;
      got_d = 1'b0;
      oe_d = 1'b0;
    end else if (stop_cond) begin
      // Stop releases the bus
      state_d = S_IDLE;
      oe_d = 1'b0;
    end else if (scl_rise) begin
      if (rx_state) begin
        // Shift in one bit
        shift_d = {shift_q[6:0], sda_s2_q};
        cnt_d = cnt_q + 3'd1;
        got_d = (cnt_q == 3'd7);
      end else if (state_q == S_RDATA) begin
        // Count a bit taken by the master
        cnt_d = cnt_q + 3'd1;
        got_d = (cnt_q == 3'd7);
      end else if (state_q == S_MACK) begin
        // Low means the master wants another byte
        got_d = !sda_s2_q;
      end
    end else if (scl_fall) begin
      case (state_q)
        S_DEV: begin
          if (got_q) begin
            got_d = 1'b0;
            if (addr_match) begin
              state_d = S_ACK;
              oe_d = 1'b1;
              after_ack_d = shift_q[0] ? S_RDATA : S_REG;
            end else begin
              state_d = S_IDLE; // Another slave is addressed
            end
          end
        end
        S_REG: begin
          if (got_q) begin
            got_d = 1'b0;
            ptr_d = shift_q; // RL9
            state_d = S_ACK;
            oe_d = 1'b1;
            after_ack_d = S_WDATA;
          end
        end
        S_WDATA: begin
          if (got_q) begin
            got_d = 1'b0;
            we_d = ptr_mapped; // RL9
            ptr_d = ptr_q + 8'h01;
            state_d = S_ACK;
            oe_d = 1'b1;
            after_ack_d = S_WDATA;
          end
        end
        S_ACK: begin
          // Release acknowledge, or drive the first read bit
          state_d = after_ack_q;
          cnt_d = 3'd0;
          got_d = 1'b0;
          oe_d = (after_ack_q == S_RDATA) ? !rd_byte[7] : 1'b0;
        end
        S_RDATA: begin
          if (got_q) begin
            got_d = 1'b0;
            oe_d = 1'b0; // Master drives its acknowledge
            ptr_d = ptr_q + 8'h01;
            state_d = S_MACK;
          end else begin
            oe_d = !rd_byte[tx_bit]; // RL9
          end
        end
        S_MACK: begin
          // Continue with the next byte or wait for stop
          cnt_d = 3'd0;
          if (got_q) begin
            state_d = S_RDATA;
            oe_d = !rd_byte[7];
          end else begin
            state_d = S_IDLE;
          end
          got_d = 1'b0;
        end
        default: state_d = S_IDLE;
      endcase
    end
  end

  // Protocol registers
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      state_q <= S_IDLE;
      after_ack_q <= S_IDLE;
      shift_q <= 8'h00;
      cnt_q <= 3'd0;
      got_q <= 1'b0;
      ptr_q <= 8'h00;
      oe_q <= 1'b0;
    end else begin
      state_q <= state_d;
      after_ack_q <= after_ack_d;
      shift_q <= shift_d;
      cnt_q <= cnt_d;
      got_q <= got_d;
      ptr_q <= ptr_d;
      oe_q <= oe_d;
    end
  end

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  logic [8*NUM_REGS-1:0] bytes; // All stored bytes
  logic [7:0] store_rdata; // Registered storage read

  osc_reg_store u_store (
    .i_core_clk(i_core_clk),
    .i_srst(i_srst),
    .i_we(we_d),
    .i_waddr(ptr_idx),
    .i_wdata(shift_q),
    .i_raddr(ptr_idx),
    .o_rdata(store_rdata),
    .o_bytes(bytes)
  );

  // Unmapped registers read as zero
  assign rd_byte = ptr_mapped ? store_rdata : RST_READ_DATA;

  // ----------------------------------------------------------------
  // Field decode
  // ----------------------------------------------------------------
  wire logic [7:0] r_div = bytes[8*0 +: 8]; // divider_select
  wire logic [7:0] r_top = bytes[8*1 +: 8]; // divider_low_and_freq_word_top
  wire logic [7:0] r_alt = bytes[8*6 +: 8]; // alt_divider_select

  wire logic [2:0] high_speed_divider_sel = r_div[HS_SEL_MSB:HS_SEL_LSB];
  wire logic [6:0] output_divider_sel = {r_div[OUT_SEL_HI_MSB:0], r_top[OUT_SEL_LO_MSB:OUT_SEL_LO_LSB]}; // RL4
  wire logic [FREQ_W-1:0] osc_freq_control_word = {r_top[FREQ_TOP_MSB:0], bytes[8*2 +: 8], bytes[8*3 +: 8],
    bytes[8*4 +: 8], bytes[8*5 +: 8]}; // RL5
  wire logic [2:0] alt_high_speed_divider_sel = r_alt[HS_SEL_MSB:HS_SEL_LSB]; // RL6
  wire logic [4:0] alt_output_divider_sel_hi = r_alt[OUT_SEL_HI_MSB:0]; // RL6

  wire logic [3:0] hs_ratio_w = hs_ratio(high_speed_divider_sel); // RL1
  wire logic [3:0] alt_hs_ratio_w = hs_ratio(alt_high_speed_divider_sel); // RL6
  // Ratio is select plus one; an even nonzero select gives an odd ratio, bumped up
  wire logic sel_odd_ratio = (output_divider_sel != 7'h00) && !output_divider_sel[0];
  wire logic [7:0] out_ratio_w = {1'b0, output_divider_sel} + (sel_odd_ratio ? 8'h02 : 8'h01); // RL2 RL3
  // Both factors widened first so the product keeps all 11 bits
  wire logic [10:0] total_w = 11'(hs_ratio_w) * 11'(out_ratio_w); // RL10

  // Decoded outputs, all from flip-flops
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      o_sda_out <= 1'b0;
      o_sda_oe <= 1'b0;
      o_hs_ratio <= 4'h0;
      o_hs_sel_unused <= 1'b0;
      o_out_div_ratio <= 8'h00;
      o_total_div_ratio <= 11'h000;
      o_osc_freq_control_word <= '0;
      o_osc_freq_int <= '0;
      o_alt_hs_ratio <= 4'h0;
      o_alt_hs_sel_unused <= 1'b0;
      o_alt_output_divider_sel_hi <= 5'h00;
    end else begin
      o_sda_out <= 1'b0; // Open drain only ever pulls low
      o_sda_oe <= oe_q;
      o_hs_ratio <= hs_ratio_w; // RL1
      o_hs_sel_unused <= (hs_ratio_w == 4'h0);
      o_out_div_ratio <= out_ratio_w; // RL3
      o_total_div_ratio <= total_w; // RL10
      o_osc_freq_control_word <= osc_freq_control_word; // RL5
      o_osc_freq_int <= osc_freq_control_word[FREQ_W-1:FREQ_FRAC_BITS]; // RL7
      o_alt_hs_ratio <= alt_hs_ratio_w; // RL6
      o_alt_hs_sel_unused <= (alt_hs_ratio_w == 4'h0);
      o_alt_output_divider_sel_hi <= alt_output_divider_sel_hi;
    end
  end

endmodule : osc_divider_freq_config_regs

`default_nettype wire

// ==== pkg/osc_cfg_pkg.sv ====
// Constants shared by the oscillator divider and frequency register bank
`default_nettype none

package osc_cfg_pkg;

  // ----------------------------------------------------------------
  // Serial slave identity and register map
  // ----------------------------------------------------------------
  localparam logic [6:0] SLAVE_ADDR = 7'h55; // Arbitrary value, set per part
  localparam logic [7:0] REG_DIVIDER_SELECT = 8'h07; // divider_select
  localparam logic [7:0] REG_DIVIDER_LOW_AND_FREQ_WORD_TOP = 8'h08;
  localparam logic [7:0] REG_FREQ_WORD_BYTE3 = 8'h09;
  localparam logic [7:0] REG_FREQ_WORD_BYTE2 = 8'h0a;
  localparam logic [7:0] REG_FREQ_WORD_BYTE1 = 8'h0b;
  localparam logic [7:0] REG_FREQ_WORD_BYTE0 = 8'h0c;
  localparam logic [7:0] REG_ALT_DIVIDER_SELECT = 8'h0d;
  localparam int NUM_REGS = 7; // Registers held by the bank
  localparam int IDX_W = 3; // Width of a storage index

  // ----------------------------------------------------------------
  // Values after reset, one per stored byte
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_DIVIDER_SELECT = 8'h00;
  localparam logic [7:0] RST_DIVIDER_LOW_AND_FREQ_WORD_TOP = 8'h00;
  localparam logic [7:0] RST_FREQ_WORD_BYTE3 = 8'h00;
  localparam logic [7:0] RST_FREQ_WORD_BYTE2 = 8'h00;
  localparam logic [7:0] RST_FREQ_WORD_BYTE1 = 8'h00;
  localparam logic [7:0] RST_FREQ_WORD_BYTE0 = 8'h00;
  localparam logic [7:0] RST_ALT_DIVIDER_SELECT = 8'h00;
  localparam logic [7:0] RST_READ_DATA = 8'h00;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int HS_SEL_MSB = 7; // high_speed_divider_sel in bits 7:5
  localparam int HS_SEL_LSB = 5;
  localparam int OUT_SEL_HI_MSB = 4; // Upper output_divider_sel bits in 4:0
  localparam int OUT_SEL_LO_MSB = 7; // Lower output_divider_sel bits in 7:6
  localparam int OUT_SEL_LO_LSB = 6;
  localparam int FREQ_TOP_MSB = 5; // Word bits 37:32 in bits 5:0
  localparam int FREQ_W = 38; // osc_freq_control_word width
  localparam int FREQ_FRAC_BITS = 28; // Word scaled down by 2**28
  localparam int FREQ_INT_W = FREQ_W - FREQ_FRAC_BITS;

  // ----------------------------------------------------------------
  // Serial slave states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    S_IDLE = 3'b000, // Waiting for a start condition
    S_DEV = 3'b001, // Receiving slave address and direction
    S_REG = 3'b010, // Receiving register number
    S_WDATA = 3'b011, // Receiving write data
    S_RDATA = 3'b100, // Sending read data
    S_ACK = 3'b101, // Driving acknowledge low
    S_MACK = 3'b110 // Sampling master acknowledge
  } slave_state_t;

endpackage : osc_cfg_pkg

`default_nettype wire

// ==== core/osc_reg_store.sv ====
// Byte storage for the divider and frequency registers with registered read
`default_nettype none

module osc_reg_store
  import osc_cfg_pkg::*;
(
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_srst,
  // Write port
  input wire logic i_we,
  input wire logic [IDX_W-1:0] i_waddr,
  input wire logic [7:0] i_wdata,
  // Read port
  input wire logic [IDX_W-1:0] i_raddr,
  output logic [7:0] o_rdata,
  // All bytes for the decoders
  output logic [8*NUM_REGS-1:0] o_bytes
);

  // Reset image, lowest register number in the low byte
  localparam logic [8*NUM_REGS-1:0] RST_IMAGE = {
    RST_ALT_DIVIDER_SELECT, RST_FREQ_WORD_BYTE0, RST_FREQ_WORD_BYTE1,
    RST_FREQ_WORD_BYTE2, RST_FREQ_WORD_BYTE3,
    RST_DIVIDER_LOW_AND_FREQ_WORD_TOP, RST_DIVIDER_SELECT};

  // ----------------------------------------------------------------
  // Storage bytes
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NUM_REGS; g++) begin : g_byte
      // One byte, written when its index is addressed
      always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
          o_bytes[8*g +: 8] <= RST_IMAGE[8*g +: 8];
        end else if (i_we && (i_waddr == IDX_W'(g))) begin
          o_bytes[8*g +: 8] <= i_wdata; // RL9
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Registered read
  // ----------------------------------------------------------------
  wire logic [7:0] rd_sel = (int'(i_raddr) < NUM_REGS) ? o_bytes[8*i_raddr +: 8] : RST_READ_DATA;

  // Read data leave through a flip-flop
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      o_rdata <= RST_READ_DATA;
    end else begin
      o_rdata <= rd_sel; // RL9
    end
  end

endmodule : osc_reg_store

`default_nettype wire

// ==== sim/osc_cfg_asserts.sv ====
// Port checker for the divider and frequency register bank
`default_nettype none

module osc_cfg_asserts
  import osc_cfg_pkg::*;
(
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_srst,
  // Serial pins
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic o_sda_out,
  input wire logic o_sda_oe,
  // Settings
  input wire logic [3:0] o_hs_ratio,
  input wire logic o_hs_sel_unused,
  input wire logic [7:0] o_out_div_ratio,
  input wire logic [10:0] o_total_div_ratio,
  input wire logic [FREQ_W-1:0] o_osc_freq_control_word,
  input wire logic [FREQ_INT_W-1:0] o_osc_freq_int,
  input wire logic [3:0] o_alt_hs_ratio,
  input wire logic o_alt_hs_sel_unused,
  input wire logic [4:0] o_alt_output_divider_sel_hi
);
  // ----
  // Settle counter
  // ----
  logic [1:0] age_q;
  logic [1:0] age_d;
  logic live; // Decoded outputs valid
  assign age_d = (age_q == 2'h3) ? age_q : age_q + 2'h1;
  assign live = (age_q == 2'h3);
  // Counts edges since reset left
  always_ff @(posedge i_core_clk) begin
    age_q <= i_srst ? 2'h0 : age_d;
  end
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_srst);
  // Divider ratios held over two edges
  sequence s_steady;
    live && $stable(o_hs_ratio) && $stable(o_out_div_ratio) ##1 $stable(o_hs_ratio) && $stable(o_out_div_ratio);
  endsequence
  // Data line pulled low after a change
  sequence s_pull_on;
    $rose(o_sda_oe);
  endsequence
  a_total_is_product: assert property (s_steady |-> o_total_div_ratio == 11'(o_hs_ratio) * o_out_div_ratio)
    else $error("total ratio wrong");
  a_hs_code_legal: assert property (live && !o_hs_sel_unused |-> o_hs_ratio inside {4, 5, 6, 7, 9, 11})
    else $error("hs ratio illegal");
  a_hs_unused_zero: assert property (live && o_hs_sel_unused |-> o_hs_ratio == 4'h0)
    else $error("unused code ratio");
  a_out_ratio_even: assert property (live |-> o_out_div_ratio == 8'h01 || (!o_out_div_ratio[0] && o_out_div_ratio inside {[2:128]}))
    else $error("out ratio odd");
  a_int_part_match: assert property (live |-> o_osc_freq_int == o_osc_freq_control_word[FREQ_W-1:FREQ_FRAC_BITS])
    else $error("integer part wrong");
  a_alt_hs_decode: assert property (live |-> (o_alt_hs_sel_unused ? o_alt_hs_ratio == 4'h0 : o_alt_hs_ratio inside {4, 5, 6, 7, 9, 11}))
    else $error("alt ratio wrong");
  a_sda_move_low: assert property (live && $changed(o_sda_oe) |-> !i_scl)
    else $error("data moved in clock high");
  a_word_move_low: assert property (live && $changed(o_osc_freq_control_word) |-> !i_scl)
    else $error("word moved in clock high");
  a_ack_hold_long: assert property (s_pull_on |-> o_sda_oe [*8])
    else $error("pull too short");
  a_sda_drives_low: assert property (o_sda_oe |-> !o_sda_out)
    else $error("data driven high");
endmodule : osc_cfg_asserts

bind osc_divider_freq_config_regs osc_cfg_asserts u_chk (.i_core_clk, .i_srst, .i_scl, .i_sda, .o_sda_out,
  .o_sda_oe, .o_hs_ratio, .o_hs_sel_unused, .o_out_div_ratio, .o_total_div_ratio,
  .o_osc_freq_control_word, .o_osc_freq_int, .o_alt_hs_ratio, .o_alt_hs_sel_unused,
  .o_alt_output_divider_sel_hi);

`default_nettype wire

// ==== sim/osc_i2c_master_model.sv ====
// Two-wire bus master model for the register bank
`default_nettype none

// Writes are issued back to back, well inside the settle limit
module osc_i2c_master_model (
  // Clock and resolved data line
  input wire logic i_core_clk,
  input wire logic i_sda,
  // Lines pulled low while high
  output logic o_scl_low,
  output logic o_sda_low,
  // Per byte: ack bit or read data
  output logic o_res_v,
  output logic [7:0] o_res_b
);
  timeunit 1ns;
  timeprecision 1ps;
  // Bus idle, both lines released
  initial begin
    o_scl_low = 1'b0;
    o_sda_low = 1'b0;
    o_res_v = 1'b0;
    o_res_b = 8'h00;
  end
  // Lines move only on falling edges
  task automatic wt(input int n);
    repeat (n) @(negedge i_core_clk);
  endtask : wt
  // Data set in clock low, sampled mid high
  task automatic bit_x(input logic b, output logic r);
    wt(5);
    o_sda_low = !b;
    wt(20);
    o_scl_low = 1'b0;
    wt(10);
    r = i_sda;
    wt(15);
    o_scl_low = 1'b1;
  endtask : bit_x
  // Start: data falls in clock high
  task automatic start();
    wt(5);
    o_sda_low = 1'b0;
    wt(20);
    o_scl_low = 1'b0;
    wt(20);
    o_sda_low = 1'b1;
    wt(20);
    o_scl_low = 1'b1;
  endtask : start
  // Stop: data rises in clock high
  task automatic stop();
    wt(5);
    o_sda_low = 1'b1;
    wt(20);
    o_scl_low = 1'b0;
    wt(20);
    o_sda_low = 1'b0;
    wt(20);
  endtask : stop
  // Byte MSB first, then the ack bit
  task automatic xb(input logic [7:0] d, input logic a, input logic rd);
    logic [7:0] r;
    logic k;
    for (int i = 7; i >= 0; i--) begin
      bit_x(d[i], r[i]);
    end
    bit_x(a, k);
    o_res_b = rd ? r : {7'h00, k};
    o_res_v = 1'b1;
    wt(1);
    o_res_v = 1'b0;
  endtask : xb
endmodule : osc_i2c_master_model

`default_nettype wire

// ==== sim/osc_divider_freq_config_regs_tb_top.sv ====
// Self-checking bench for the divider and frequency register bank
`default_nettype none
`define CHK(x, y) begin checks_done++; if ((x) !== (y)) begin num_errors++; $display("MISMATCH %0t got %h want %h", $time, (x), (y)); end end

module osc_divider_freq_config_regs_tb_top
  import osc_cfg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ----
  // Signals
  // ----
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic probe = 1'b0;
  logic m_scl_low, m_sda_low, sda_oe, sda_out, res_v, hsu, ahsu;
  logic [3:0] hs, ahs;
  logic [4:0] ahi;
  logic [7:0] od, res_b;
  logic [10:0] tot;
  logic [37:0] fw;
  logic [71:0] outv, e;
  logic [71:0] ex[$]; // Expected results, oldest first
  logic [7:0] sh[7]; // Shadow of registers 7..13
  logic [7:0] wd[7]; // Bytes of the next write
  int num_errors = 0;
  int checks_done = 0;
  int seed = 32'h061b;
  wire scl = !m_scl_low;
  wire sda = !(m_sda_low || (sda_oe && !sda_out)); // Pulled up
  assign outv = {ahi, ahsu, ahs, tot, od, hsu, hs, fw};
  always #5 clk = !clk;

  osc_divider_freq_config_regs i_dut (.i_core_clk(clk), .i_srst(srst), .i_scl(scl), .i_sda(sda),
    .o_sda_out(sda_out), .o_sda_oe(sda_oe), .o_hs_ratio(hs), .o_hs_sel_unused(hsu),
    .o_out_div_ratio(od), .o_total_div_ratio(tot), .o_osc_freq_control_word(fw), .o_osc_freq_int(),
    .o_alt_hs_ratio(ahs), .o_alt_hs_sel_unused(ahsu), .o_alt_output_divider_sel_hi(ahi));
  osc_i2c_master_model m (.i_core_clk(clk), .i_sda(sda), .o_scl_low(m_scl_low), .o_sda_low(m_sda_low),
    .o_res_v(res_v), .o_res_b(res_b));

  // High speed select decode
  function automatic logic [3:0] hsr(input logic [2:0] c);
    case (c)
      3'h0, 3'h1, 3'h2, 3'h3: return 4'(c) + 4'h4;
      3'h5: return 4'h9;
      3'h7: return 4'hb;
      default: return 4'h0;
    endcase
  endfunction : hsr
  // Expected outputs from the shadow
  function automatic logic [71:0] expv();
    logic [3:0] h, ah;
    logic [7:0] o;
    h = hsr(sh[0][7:5]);
    ah = hsr(sh[6][7:5]);
    o = {1'b0, sh[0][4:0], sh[1][7:6]} + 8'h01;
    if (o > 8'h01 && o[0]) o = o + 8'h01;
    return {sh[6][4:0], ah == 4'h0, ah, 11'(h) * 11'(o), o, h == 4'h0, h, sh[1][5:0], sh[2], sh[3], sh[4], sh[5]};
  endfunction : expv
  // Write n bytes from register rn
  task automatic wr(input logic [6:0] sa, input logic [7:0] rn, input int n);
    logic k;
    k = (sa !== SLAVE_ADDR);
    m.start();
    ex.push_back({71'h0, k});
    m.xb({sa, 1'b0}, 1'b1, 1'b0);
    if (!k) begin
      ex.push_back(72'h0);
      m.xb(rn, 1'b1, 1'b0);
      for (int i = 0; i < n; i++) begin
        ex.push_back(72'h0);
        m.xb(wd[i], 1'b1, 1'b0);
        if (rn + i >= 7 && rn + i <= 13) sh[rn + i - 7] = wd[i];
      end
    end
    m.stop();
  endtask : wr
  // Read n bytes from register rn
  task automatic rd(input logic [7:0] rn, input int n);
    m.start();
    repeat (3) ex.push_back(72'h0);
    m.xb({SLAVE_ADDR, 1'b0}, 1'b1, 1'b0);
    m.xb(rn, 1'b1, 1'b0);
    m.start();
    m.xb({SLAVE_ADDR, 1'b1}, 1'b1, 1'b0);
    for (int i = 0; i < n; i++) begin
      ex.push_back((rn + i >= 7 && rn + i <= 13) ? 72'(sh[rn + i - 7]) : 72'h0);
      m.xb(8'hff, i == n - 1, 1'b1);
    end
    m.stop();
  endtask : rd
  // Note the settings and flag them for the watcher
  task automatic chk_out();
    repeat (10) @(negedge clk);
    ex.push_back(expv());
    probe = 1'b1;
    @(negedge clk);
    probe = 1'b0;
  endtask : chk_out
  // Verdict and end of run
  task automatic test_done();
    if (num_errors == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : test_done

  // Watcher: oldest note against each result
  always @(posedge clk) begin
    if (res_v || probe) begin
      if (ex.size() == 0) begin
        `CHK(1'b1, 1'b0)
      end else begin
        e = ex.pop_front();
        if (probe) `CHK(outv, e)
        else `CHK({64'h0, res_b}, e)
      end
    end
  end
  // Main sequence
  initial begin
    sh = '{default: 8'h00};
    repeat (12) @(negedge clk);
    srst = 1'b0;
    repeat (3) @(negedge clk);
    rd(8'h07, 7);
    chk_out();
    // Every select code, ratio 1 and 128 at the ends
    for (int it = 0; it < 8; it++) begin
      foreach (wd[j]) wd[j] = 8'($random(seed));
      wd[0][7:5] = 3'(it);
      if (it == 0) {wd[0][4:0], wd[1][7:6]} = 7'h00;
      if (it == 7) {wd[0][4:0], wd[1][7:6]} = 7'h7f;
      wr(SLAVE_ADDR, 8'h07, 7);
      chk_out();
    end
    rd(8'h07, 7);
    // Foreign address ignored, then writes past the map end
    wr(7'h2a, 8'h07, 1);
    wr(SLAVE_ADDR, 8'h0c, 3);
    rd(8'h0c, 3);
    chk_out();
    `CHK(ex.size(), 0)
    test_done();
  end
  // Hang limit
  initial begin
    repeat (100000) @(posedge clk);
    `CHK(1'b0, 1'b1)
    test_done();
  end
endmodule : osc_divider_freq_config_regs_tb_top

`default_nettype wire
